//--- include/acq_pkg.sv
// Shared constants, state enumeration and register structs of the acquisition sequencer.
package acq_pkg;

	// Clock rate and the one-microsecond tick derived from it.
	localparam int CLK_PERIOD_NS = 10;
	localparam int US_NS = 1000;
	localparam int TICK_CYCLES = US_NS / CLK_PERIOD_NS;
	localparam int PRE_W = 7;

	// Trigger latency window; least time rounds up, longest rounds down.
	localparam int TRIG_DLY_MIN_NS = 20;
	localparam int TRIG_DLY_MAX_NS = 30;
	localparam int TRIG_DLY_MIN_CYC = (TRIG_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIG_DLY_MAX_CYC = TRIG_DLY_MAX_NS / CLK_PERIOD_NS;

	// Initial busy interval: one microsecond in level mode, 15 ns in edge mode.
	localparam int LEVEL_BUSY1_US = 1;
	localparam int LEVEL_BUSY1_CYC = LEVEL_BUSY1_US * US_NS / CLK_PERIOD_NS;
	localparam int EDGE_BUSY1_NS = 15;
	localparam int EDGE_BUSY1_CYC = (EDGE_BUSY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYC_W = 7;

	// Microsecond counter widths and programmable limits.
	localparam int US_W = 23;
	localparam int ACQ_W = 19;
	localparam int ACQ_DLY_MAX_US = 335500;
	localparam int EDGE_INTEG_MIN_US = 7200;
	localparam int EDGE_INTEG_MAX_US = 5000000;
	localparam int LEVEL_PULSE_MAX_US = 6000000;

	// Sequencer phases, in the order a cycle walks them.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY1,
		ST_ACQ,
		ST_INTEG,
		ST_BUSY2
	} seq_state_t;

	// Complete state of the sequencer.
	typedef struct packed {
		seq_state_t state;
		logic level;
		logic [2:0] sync;
		logic trig_evt;
		logic [CYC_W-1:0] cyc;
		logic [PRE_W-1:0] pre;
		logic [PRE_W-1:0] tpre;
		logic [US_W-1:0] phase_us;
		logic [US_W-1:0] since_us;
		logic [US_W-1:0] width_us;
		logic [US_W-1:0] integ_us;
		logic [ACQ_W-1:0] acq_us;
		logic [US_W-1:0] ss_dly;
		logic [US_W-1:0] ss_w;
		logic ss_done;
		logic ss;
		logic err;
		logic done;
	} seq_regs_t;

	// Complete state of the periodic strobe generator.
	typedef struct packed {
		logic [US_W-1:0] phase;
		logic allow;
		logic strobe;
	} ps_regs_t;

endpackage

//--- include/periodic_strobe_if.sv
// Link between the sequencer and its periodic strobe generator.
`timescale 1ns/1ps
interface periodic_strobe_if import acq_pkg::*; ();
	logic run; // High while integrating.
	logic full_only; // Only whole periods may be emitted.
	logic tick; // One-microsecond tick aligned to integration start.
	logic [US_W-1:0] period; // Period in microseconds.
	logic [US_W-1:0] off_time; // Low time at the start of each period.
	logic [US_W-1:0] remain; // Microseconds of integration left.
	logic strobe; // Registered periodic strobe.

	modport ctrl (output run, output full_only, output tick, output period, output off_time, output remain,
		input strobe);
	modport gen (input run, input full_only, input tick, input period, input off_time, input remain,
		output strobe);
endinterface

//--- hw/periodic_strobe.sv
// Periodic strobe generator that runs only while integration is in progress.
`timescale 1ns/1ps
module periodic_strobe import acq_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	periodic_strobe_if.gen bus
);

	ps_regs_t q; // Registered state.
	ps_regs_t d; // Next state.
	logic allow_now; // Current period is allowed to show its high part.

	// Decide per period whether it may appear, then walk the phase on each tick.
	always_comb begin
		d = q;
		if (q.phase == '0) begin
			// A period only starts if it fits when whole periods are demanded.
			allow_now = (bus.period != '0) && (!bus.full_only || bus.remain >= bus.period);
		end else begin
			allow_now = q.allow;
		end
		d.allow = allow_now;
		// Low for the off time, high for the rest of the period.
		d.strobe = bus.run && allow_now && (q.phase >= bus.off_time);
		if (!bus.run) begin
			// Dropping run forces the strobe low, even mid-period.
			d.phase = '0;
			d.allow = 1'b0;
		end else if (bus.tick) begin
			if (q.phase + US_W'(1) >= bus.period) begin
				d.phase = '0;
			end else begin
				d.phase = q.phase + US_W'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus.strobe = q.strobe;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_off_time_low: assert property (q.strobe |-> $past(q.phase) >= $past(bus.off_time))
		else $error("periodic strobe high inside its off time");
	a_whole_period: assert property ((bus.run && bus.full_only && q.phase == '0 && bus.remain < bus.period)
		|=> !q.strobe)
		else $error("partial periodic strobe period in edge mode");
	a_stops_with_run: assert property (!bus.run |=> !q.strobe)
		else $error("periodic strobe outlived integration");

endmodule // periodic_strobe

//--- hw/acq_sequencer.sv
// Acquisition timing sequencer for external edge and level trigger modes.
`timescale 1ns/1ps
// What this block does
// - Level mode: trigger high time sets integration
// - Trigger event 20 to 30 ns after edge
// - Fixed initial busy, per trigger mode
// - Programmable acquisition delay in microsecond steps
// - Short level pulse flags error, zeroes data
// - Single strobe delay and width, ends at integration
// - Level mode periodic strobe cut at integration end
// - Periodic strobe period programmable, negated after integration
// - Edge mode integration programmed, clamped to limits
// - Programmable periodic off time each period
// - Edge mode starts on trigger rising edge
// - Latency, busy plus delay, integration, final busy
// - Edge mode emits only whole periodic periods
// - Single strobe delay counted from trigger event
module acq_sequencer import acq_pkg::*; #(
	parameter int EDGE_FINAL_BUSY_US = 4977, // Final busy after an edge-mode cycle.
	parameter int LEVEL_FINAL_BUSY_US = 218, // Final busy after a level-mode cycle.
	parameter int LEVEL_MIN_PULSE_US = 220, // Shortest valid level trigger pulse.
	parameter int PIX_W = 16 // Width of one spectrum value.
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic ext_trigger,
	input wire logic level_mode,
	input wire logic [US_W-1:0] integ_time_us,
	input wire logic [ACQ_W-1:0] acq_delay_us,
	input wire logic [US_W-1:0] ss_delay_us,
	input wire logic [US_W-1:0] ss_width_us,
	input wire logic [US_W-1:0] ps_period_us,
	input wire logic [US_W-1:0] ps_off_us,
	input wire logic [PIX_W-1:0] pixel_in,
	output logic [PIX_W-1:0] pixel_out,
	output logic trigger_event,
	output logic busy,
	output logic integrating,
	output logic single_strobe,
	output logic periodic_strobe_out,
	output logic short_pulse_err,
	output logic cycle_done
);

	// Refuse settings the counters cannot hold.
	if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << PRE_W)) begin : g_bad_tick
		$error("tick prescaler does not fit");
	end
	if (LEVEL_BUSY1_CYC >= (1 << CYC_W) || EDGE_BUSY1_CYC < 1) begin : g_bad_busy1
		$error("initial busy count does not fit");
	end
	if (EDGE_FINAL_BUSY_US < 1 || LEVEL_FINAL_BUSY_US < 1 || LEVEL_MIN_PULSE_US < 1) begin : g_bad_times
		$error("final busy and minimum pulse must be at least one microsecond");
	end
	if (ACQ_DLY_MAX_US >= (1 << ACQ_W) || LEVEL_PULSE_MAX_US >= (1 << US_W)) begin : g_bad_width
		$error("counter widths too small");
	end

	logic [1:0] rst_sync_q; // Reset release synchroniser.
	logic rst_n; // Synchronised reset used by the rest of the design.
	seq_regs_t q; // Registered sequencer state.
	seq_regs_t d; // Next sequencer state.
	logic [PIX_W-1:0] pixel_q; // Registered outgoing spectrum value.
	logic rise; // Synchronised trigger rising edge.
	logic fall; // Synchronised trigger falling edge.
	logic trig_hi; // Synchronised trigger level.
	logic ptick; // Microsecond tick of the current phase.
	logic ttick; // Microsecond tick counted from the trigger event.
	logic [US_W-1:0] integ_sel; // Edge integration time after clamping.
	logic [CYC_W-1:0] busy1_last; // Last cycle of the initial busy interval.
	logic [US_W-1:0] busy2_us; // Final busy length for the current mode.
	logic to_integ; // Integration starts at this edge.
	logic to_busy2; // Integration ends at this edge.
	logic short_now; // Level pulse ended before its minimum width.

	periodic_strobe_if ps_bus ();

	// Reset is applied at once but released only after two clean edges.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Only the second and third synchroniser stages are ever looked at.
	assign rise = q.sync[1] && !q.sync[2];
	assign fall = !q.sync[1] && q.sync[2];
	assign trig_hi = q.sync[1];
	assign ptick = (q.pre == PRE_W'(TICK_CYCLES - 1));
	assign ttick = (q.tpre == PRE_W'(TICK_CYCLES - 1));

	// Edge integration is held inside its legal window whatever software writes.
	always_comb begin
		if (integ_time_us < US_W'(EDGE_INTEG_MIN_US)) begin
			integ_sel = US_W'(EDGE_INTEG_MIN_US);
		end else if (integ_time_us > US_W'(EDGE_INTEG_MAX_US)) begin
			integ_sel = US_W'(EDGE_INTEG_MAX_US);
		end else begin
			integ_sel = integ_time_us;
		end
	end

	// The fixed busy intervals that differ between the two modes.
	assign busy1_last = q.level ? CYC_W'(LEVEL_BUSY1_CYC - 1) : CYC_W'(EDGE_BUSY1_CYC - 1);
	assign busy2_us = q.level ? US_W'(LEVEL_FINAL_BUSY_US) : US_W'(EDGE_FINAL_BUSY_US);
	assign short_now = (q.width_us < US_W'(LEVEL_MIN_PULSE_US));

	// Next-state logic of the whole acquisition cycle.
	always_comb begin
		d = q;
		to_integ = 1'b0;
		to_busy2 = 1'b0;
		d.trig_evt = 1'b0;
		d.done = 1'b0;
		// The first stage is read only by the second stage. Edge pulses under 10 ns may be missed.
		d.sync = {q.sync[1:0], ext_trigger};
		d.pre = ptick ? '0 : q.pre + PRE_W'(1);
		d.tpre = ttick ? '0 : q.tpre + PRE_W'(1);
		if (ptick) begin
			d.phase_us = q.phase_us + US_W'(1);
		end
		// Counters saturate so a stuck trigger cannot wrap them.
		if (ttick && q.since_us != '1) begin
			d.since_us = q.since_us + US_W'(1);
		end
		if (ttick && trig_hi && q.state != ST_IDLE && q.width_us != '1) begin
			d.width_us = q.width_us + US_W'(1);
		end
		case (q.state)
			ST_IDLE: begin
				// A rising edge becomes the trigger event one registered stage later.
				if (rise && !q.trig_evt) begin
					d.trig_evt = 1'b1;
				end
				if (q.trig_evt) begin
					// Configuration except the periodic strobe period and off time is frozen for the whole cycle at the trigger event.
					d.state = ST_BUSY1;
					d.level = level_mode;
					d.integ_us = integ_sel;
					d.acq_us = acq_delay_us;
					d.ss_dly = ss_delay_us;
					d.ss_w = ss_width_us;
					d.cyc = '0;
					d.tpre = '0;
					d.since_us = '0;
					d.width_us = '0;
					d.err = 1'b0;
					d.ss_done = 1'b0;
				end
			end
			ST_BUSY1: begin
				d.cyc = q.cyc + CYC_W'(1);
				if (q.level && fall) begin
					// The pulse ended before integration could start.
					d.err = 1'b1;
					to_busy2 = 1'b1;
				end else if (q.cyc == busy1_last) begin
					if (q.acq_us == '0) begin
						to_integ = 1'b1;
					end else begin
						d.state = ST_ACQ;
						d.pre = '0;
						d.phase_us = '0;
					end
				end
			end
			ST_ACQ: begin
				if (q.level && fall) begin
					d.err = 1'b1;
					to_busy2 = 1'b1;
				end else if (ptick && q.phase_us + US_W'(1) == US_W'(q.acq_us)) begin
					to_integ = 1'b1;
				end
			end
			ST_INTEG: begin
				if (q.level) begin
					// The software integration time is not consulted here.
					if (fall) begin
						d.err = short_now;
						to_busy2 = 1'b1;
					end else if (ptick && q.phase_us + US_W'(1) == US_W'(LEVEL_PULSE_MAX_US)) begin
						to_busy2 = 1'b1;
					end
				end else if (ptick && q.phase_us + US_W'(1) == q.integ_us) begin
					to_busy2 = 1'b1;
				end
			end
			ST_BUSY2: begin
				if (ptick && q.phase_us + US_W'(1) == busy2_us) begin
					d.state = ST_IDLE;
					d.done = 1'b1;
				end
			end
			default: begin
				d.state = ST_IDLE;
			end
		endcase
		if (to_integ) begin
			// Phase timing restarts so the periodic strobe aligns to integration start.
			d.state = ST_INTEG;
			d.pre = '0;
			d.phase_us = '0;
		end
		if (to_busy2) begin
			d.state = ST_BUSY2;
			d.pre = '0;
			d.phase_us = '0;
			d.ss_done = 1'b1;
		end
		// Single strobe window measured from the trigger event, cut when integration ends.
		d.ss = (q.state != ST_IDLE) && !d.ss_done && (q.ss_w != '0) && (q.since_us >= q.ss_dly)
			&& (q.since_us - q.ss_dly < q.ss_w);
	end

	// State register; reset leaves the single strobe disarmed.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.ss_done <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// A flagged cycle hands on an all-zero spectrum.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pixel_q <= '0;
		end else begin
			pixel_q <= q.err ? '0 : pixel_in;
		end
	end

	// Periodic strobe runs only in integration; whole periods only in edge mode.
	assign ps_bus.run = (q.state == ST_INTEG);
	assign ps_bus.full_only = !q.level;
	assign ps_bus.tick = ptick;
	assign ps_bus.period = ps_period_us;
	assign ps_bus.off_time = ps_off_us;
	assign ps_bus.remain = q.integ_us - q.phase_us;

	periodic_strobe u_periodic_strobe (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.bus(ps_bus)
	);

	assign pixel_out = pixel_q;
	assign trigger_event = q.trig_evt;
	assign busy = (q.state != ST_IDLE) || q.trig_evt;
	assign integrating = (q.state == ST_INTEG);
	assign single_strobe = q.ss;
	assign periodic_strobe_out = ps_bus.strobe;
	assign short_pulse_err = q.err;
	assign cycle_done = q.done;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_edge_seen;
		q.state == ST_IDLE && rise && !q.trig_evt;
	endsequence
	sequence s_event_then_busy;
		q.trig_evt ##1 (q.state == ST_BUSY1 && q.cyc == '0);
	endsequence
	sequence s_integ_done;
		q.state == ST_INTEG ##1 q.state == ST_BUSY2;
	endsequence

	a_trigger_latency: assert property (s_edge_seen |=> s_event_then_busy)
		else $error("trigger event not raised one cycle after the synchronised edge");
	a_initial_busy_len: assert property ((q.state == ST_BUSY1 && $fell(q.state == ST_BUSY1) == 1'b0
		&& d.state != ST_BUSY1 && !fall) |-> q.cyc == busy1_last)
		else $error("initial busy left at the wrong cycle");
	a_acq_delay_len: assert property ((q.state == ST_ACQ && d.state == ST_INTEG)
		|-> q.phase_us + US_W'(1) == US_W'(q.acq_us) && ptick)
		else $error("acquisition delay ended at the wrong microsecond");
	a_edge_integ_len: assert property ((!q.level && q.state == ST_INTEG && d.state == ST_BUSY2)
		|-> q.phase_us + US_W'(1) == q.integ_us && q.integ_us >= US_W'(EDGE_INTEG_MIN_US))
		else $error("edge integration length differs from the programmed time");
	a_level_fall_ends: assert property ((q.level && q.state == ST_INTEG && fall) |=> q.state == ST_BUSY2)
		else $error("falling trigger did not end level integration");
	a_short_pulse_err: assert property ((q.level && q.state == ST_INTEG && fall && short_now)
		|=> short_pulse_err ##2 pixel_out == '0)
		else $error("short level pulse not flagged or data not zeroed");
	a_single_strobe_cut: assert property (s_integ_done |-> ##1 !single_strobe)
		else $error("single strobe still high after integration");
	a_strobe_from_event: assert property ($rose(single_strobe) |-> $past(q.since_us) == q.ss_dly)
		else $error("single strobe rose at the wrong delay from the trigger event");
	a_periodic_negated: assert property ((q.state == ST_BUSY2) |=> !periodic_strobe_out)
		else $error("periodic strobe high after integration");
	a_final_busy_len: assert property ((q.state == ST_BUSY2 && d.state == ST_IDLE)
		|-> q.phase_us + US_W'(1) == busy2_us ##1 cycle_done)
		else $error("final busy length wrong");

endmodule // acq_sequencer

//--- bench/trigger_partner.sv
// Model of the outside trigger source and of the equipment that the strobes drive.
`timescale 1ns/1ps
module trigger_partner (
	input wire logic core_clk,
	output logic ext_trigger,
	input wire logic single_strobe,
	input wire logic periodic_strobe_out
);
	int ps_rises; // Rising edges of the periodic strobe seen by the equipment.
	int ss_rises; // Rising edges of the single strobe seen by the equipment.
	logic ps_p; // Periodic strobe at the previous edge.
	logic ss_p; // Single strobe at the previous edge.

	// The source idles low and changes its pin just after a clock edge, by non-blocking assignment.
	initial begin
		ext_trigger = 1'b0;
		ps_rises = 0;
		ss_rises = 0;
	end

	// One trigger pulse; the caller picks a width that keeps the source's own limits.
	task automatic pulse(input int n_cyc);
		@(posedge core_clk);
		ext_trigger <= 1'b1;
		repeat (n_cyc) @(posedge core_clk);
		ext_trigger <= 1'b0;
	endtask

	// The equipment counts the strobe pulses it receives.
	always @(posedge core_clk) begin
		if (periodic_strobe_out === 1'b1 && ps_p !== 1'b1) begin
			ps_rises <= ps_rises + 1;
		end
		if (single_strobe === 1'b1 && ss_p !== 1'b1) begin
			ss_rises <= ss_rises + 1;
		end
		ps_p <= periodic_strobe_out;
		ss_p <= single_strobe;
	end
endmodule // trigger_partner

//--- bench/external_trigger_acq_sequencer_tb_top.sv
// Self-checking testbench of the acquisition sequencer.
`timescale 1ns/1ps
module external_trigger_acq_sequencer_tb_top import acq_pkg::*; ();
	localparam int FB = 3; // Shortened final busy, in microseconds.
	localparam int MINP = 5; // Shortened least level pulse, in microseconds.
	localparam logic [15:0] PIX = 16'h5A3C; // Spectrum value passed through.
	logic core_clk, reset_n, ext_trigger, level_mode;
	logic [US_W-1:0] integ_time_us, ss_delay_us, ss_width_us, ps_period_us, ps_off_us;
	logic [ACQ_W-1:0] acq_delay_us;
	logic [15:0] pixel_in, pixel_out;
	logic trigger_event, busy, integrating, single_strobe, periodic_strobe_out, short_pulse_err, cycle_done;
	int n_mismatch, tests_run, cyc, n_evt;
	int t_pin, t_pfall, t_evt, t_ir, t_if, t_sr, t_sf, t_pr, t_pf, t_done; // Edge stamps in cycles.
	logic trg_p, int_p, ss_p, ps_p, ps_at_fall;

	acq_sequencer #(.EDGE_FINAL_BUSY_US(FB), .LEVEL_FINAL_BUSY_US(FB), .LEVEL_MIN_PULSE_US(MINP), .PIX_W(16)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .ext_trigger(ext_trigger), .level_mode(level_mode),
		.integ_time_us(integ_time_us), .acq_delay_us(acq_delay_us), .ss_delay_us(ss_delay_us),
		.ss_width_us(ss_width_us), .ps_period_us(ps_period_us), .ps_off_us(ps_off_us), .pixel_in(pixel_in),
		.pixel_out(pixel_out), .trigger_event(trigger_event), .busy(busy), .integrating(integrating),
		.single_strobe(single_strobe), .periodic_strobe_out(periodic_strobe_out),
		.short_pulse_err(short_pulse_err), .cycle_done(cycle_done));

	trigger_partner partner (.core_clk(core_clk), .ext_trigger(ext_trigger), .single_strobe(single_strobe),
		.periodic_strobe_out(periodic_strobe_out));

	// A 100 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Stamps every edge of interest, so each scenario judges timing after the fact.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (ext_trigger === 1'b1 && trg_p === 1'b0) t_pin <= cyc;
		if (ext_trigger === 1'b0 && trg_p === 1'b1) t_pfall <= cyc;
		if (trigger_event === 1'b1) begin
			t_evt <= cyc;
			n_evt <= n_evt + 1;
		end
		if (integrating === 1'b1 && int_p !== 1'b1) t_ir <= cyc;
		if (integrating === 1'b0 && int_p === 1'b1) begin
			t_if <= cyc;
			ps_at_fall <= ps_p;
		end
		if (single_strobe === 1'b1 && ss_p !== 1'b1) t_sr <= cyc;
		if (single_strobe === 1'b0 && ss_p === 1'b1) t_sf <= cyc;
		if (periodic_strobe_out === 1'b1 && ps_p !== 1'b1 && t_pr < 0) t_pr <= cyc;
		if (periodic_strobe_out === 1'b0 && ps_p === 1'b1 && t_pf < 0) t_pf <= cyc;
		if (cycle_done === 1'b1) t_done <= cyc;
		trg_p <= ext_trigger;
		int_p <= integrating;
		ss_p <= single_strobe;
		ps_p <= periodic_strobe_out;
	end

	// Counts one comparison and reports it when it fails.
	task automatic check(input bit ok, input string msg);
		tests_run++;
		if (!ok) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	// True when v lies in the closed range lo..hi.
	function automatic bit inr(input int v, input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction

	// Forgets the periodic strobe stamps and the counts; called on an edge when no stamp is due, so racing the stamp process does no harm.
	task automatic clr();
		t_pr = -1;
		t_pf = -1;
		n_evt = 0;
		partner.ps_rises = 0;
		partner.ss_rises = 0;
	endtask

	// Waits for the end of a cycle, bounded so a stuck sequencer cannot hang the run.
	task automatic wait_done(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge core_clk);
			#1;
			// Looked at once the edge has settled, while the one-cycle pulse still stands.
			if (cycle_done === 1'b1) break;
		end
	endtask

	// Edge mode start-up, strobes, then an abort by reset in mid-integration.
	task automatic edge_run();
		@(posedge core_clk);
		level_mode <= 1'b0;
		// Below the edge minimum, so only the clamp keeps integration running past 5 us.
		integ_time_us <= 23'h000005;
		acq_delay_us <= 19'h00002;
		ss_delay_us <= 23'h000001;
		ss_width_us <= 23'h000002;
		ps_period_us <= 23'h000004; // Below integration time.
		ps_off_us <= 23'h000001;
		repeat (2) @(posedge core_clk);
		clr();
		check(single_strobe === 1'b0 && busy === 1'b0, "strobe or busy before trigger");
		partner.pulse(3);
		repeat (900) @(posedge core_clk);
		check(inr(t_evt - t_pin, TRIG_DLY_MIN_CYC, TRIG_DLY_MAX_CYC), "trigger latency");
		check(n_evt == 1, "trigger event count");
		check(inr(t_ir - t_evt, 1 + EDGE_BUSY1_CYC + 2 * TICK_CYCLES, 2 + EDGE_BUSY1_CYC + 2 * TICK_CYCLES),
			"edge integration start");
		check(inr(t_sr - t_evt, TICK_CYCLES, TICK_CYCLES + 4), "single strobe delay");
		check(inr(t_sf - t_sr, 2 * TICK_CYCLES - 1, 2 * TICK_CYCLES + 1), "single strobe width");
		check(inr(t_pr - t_ir, TICK_CYCLES, TICK_CYCLES + 2), "periodic off time");
		check(inr(t_pf - t_pr, 3 * TICK_CYCLES - 1, 3 * TICK_CYCLES + 1), "periodic high time");
		check(partner.ps_rises == 2, "periodic pulse count");
		check(partner.ss_rises == 1, "single strobe pulse count");
		check(integrating === 1'b1 && busy === 1'b1, "edge integration ended early");
		reset_n <= 1'b0;
		@(posedge core_clk);
		#1;
		check(busy === 1'b0 && integrating === 1'b0 && single_strobe === 1'b0 && periodic_strobe_out === 1'b0
			&& pixel_out === 16'h0000, "outputs in reset");
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	// Level pulse shorter than the least width, with a refused trigger during final busy.
	task automatic level_short();
		@(posedge core_clk);
		level_mode <= 1'b1;
		acq_delay_us <= 19'h00000;
		ps_period_us <= 23'h000000;
		clr();
		partner.pulse(3 * TICK_CYCLES); // Deliberately below the least width.
		repeat (10) @(posedge core_clk);
		#1;
		check(short_pulse_err === 1'b1 && pixel_out === 16'h0000, "short pulse not flagged");
		partner.pulse(5);
		wait_done(FB * TICK_CYCLES + 100);
		check(cycle_done === 1'b1 && busy === 1'b0, "short cycle did not finish");
		check(n_evt == 1, "trigger taken while busy");
	endtask

	// Level cycle whose pulse width sets integration; strobes are cut at its end.
	task automatic level_run();
		@(posedge core_clk);
		ss_delay_us <= 23'h000000;
		ss_width_us <= 23'h0003E8;
		ps_period_us <= 23'h00000A;
		ps_off_us <= 23'h000002;
		clr();
		partner.pulse(30 * TICK_CYCLES);
		wait_done(FB * TICK_CYCLES + 100);
		// One more edge lets the stamp process record the done pulse.
		@(posedge core_clk);
		#1;
		check(inr(t_ir - t_evt, 1 + LEVEL_BUSY1_CYC, 2 + LEVEL_BUSY1_CYC), "level integration start");
		check(inr(t_if - t_pfall, 2, 4), "integration end vs trigger fall");
		check(inr(t_if - t_sf, -1, 1), "single strobe not cut");
		check(partner.ss_rises == 1, "single strobe pulse count");
		check(ps_at_fall === 1'b1 && partner.ps_rises == 3, "periodic strobe not cut");
		check(periodic_strobe_out === 1'b0, "periodic strobe after integration");
		check(inr(t_done - t_if, FB * TICK_CYCLES - 1, FB * TICK_CYCLES + 2), "final busy length");
		check(short_pulse_err === 1'b0 && pixel_out === PIX, "good pulse flagged");
	endtask

	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short; the scenarios need well under 20000 cycles.
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end

	// Main sequence: reset for eight cycles, then the scenarios.
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		cyc = 0;
		reset_n = 1'b0;
		level_mode = 1'b0;
		integ_time_us = 23'h001C20;
		acq_delay_us = 19'h00000;
		ss_delay_us = 23'h000000;
		ss_width_us = 23'h000000;
		ps_period_us = 23'h000000;
		ps_off_us = 23'h000000;
		pixel_in = PIX;
		clr();
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		edge_run();
		level_short();
		level_run();
		tally_and_finish();
	end
endmodule // external_trigger_acq_sequencer_tb_top
